// ---- hw/ccsr_pkg.sv ----
package ccsr_pkg;

    // register offsets (byte addresses on the register port)
    localparam logic [11:0] OFS_OSC = 12'h000;
    localparam logic [11:0] OFS_PIN_IO = 12'h004;
    localparam logic [11:0] OFS_CRC = 12'h008;
    localparam logic [11:0] OFS_RAM_CORR_CTRL = 12'h00c;
    localparam logic [11:0] OFS_RAM_CORR_STAT = 12'h010;
    localparam logic [11:0] OFS_PART_ID = 12'h014;

    // reset values and writable-bit masks
    localparam logic [31:0] OSC_RST = 32'h0000_0060;
    localparam logic [31:0] OSC_WMASK = 32'h0000_0079;
    localparam logic [31:0] OSC_CFG_ONLY = 32'h0000_0011;
    localparam logic [31:0] IO_RST = 32'h0300_0003;
    localparam logic [31:0] IO_WMASK = 32'h7300_0343;
    localparam logic [31:0] CRC_WMASK = 32'h0300_0000;
    localparam logic [31:0] ECC_RST = 32'h0000_0000;
    localparam logic [31:0] ECC_WMASK = 32'h0000_7f07;

    // oscillator control fields
    localparam int OSC_PLL_SEL = 0;
    localparam int OSC_OFF = 2;
    localparam int OSC_DEEP_SEL = 3;
    localparam int OSC_HALF = 4;
    localparam int OSC_DIV_LO = 5;
    localparam int OSC_DIV_HI = 6;

    // pin control fields
    localparam int IO_DIR0 = 0;
    localparam int IO_DIR1 = 1;
    localparam int IO_STBY_EN = 6;
    localparam int IO_PIN0_DRIVE_LATCH = 8;
    localparam int IO_PIN1_DRIVE_LATCH = 9;
    localparam int IO_FN0 = 24;
    localparam int IO_FN1 = 25;
    localparam int IO_TX_OD = 28;
    localparam int IO_SOF_SEL = 29;
    localparam int IO_IRQ_OD = 30;

    // command crc and ram correction fields
    localparam int CRC_ERR_IE = 24;
    localparam int CRC_FMT_IE = 25;
    localparam int CRC_ERR_FLAG = 16;
    localparam int CRC_FMT_FLAG = 17;
    localparam int ECC_EN = 0;
    localparam int ECC_SEC_IE = 1;
    localparam int ECC_DED_IE = 2;
    localparam int ECC_PAR_LO = 8;
    localparam int ECC_PAR_HI = 14;
    localparam int ECC_SEC_FLAG = 1;
    localparam int ECC_DED_FLAG = 2;

    // clock output half periods, in system clock cycles, per divisor code
    localparam logic [3:0] CLOCK_OUT_PIN_HALF_DIV1 = 4'h1;
    localparam logic [3:0] CLOCK_OUT_PIN_HALF_DIV2 = 4'h2;
    localparam logic [3:0] CLOCK_OUT_PIN_HALF_DIV4 = 4'h4;
    localparam logic [3:0] CLOCK_OUT_PIN_HALF_DIV10 = 4'ha;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } ccsr_req_t;

    typedef enum logic [2:0] {
        ST_AWAKE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_DEEP = 3'b100
    } ccsr_state_t;

endpackage

// ---- hw/ccsr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs #(
    parameter logic [3:0] DEV_ID = 4'h5,  // arbitrary value
    parameter logic [3:0] DEV_REV = 4'h1  // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire ccsr_pkg::ccsr_req_t reg_req,
    output logic [31:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // mode and clock status from the controller core
    input wire logic config_mode,
    input wire logic sleep_request,
    input wire logic wake_irq_enable,
    input wire logic cs_asserted,
    input wire logic bus_rx_activity,
    input wire logic osc_stable,
    input wire logic pll_locked,
    // core signals routed to pins
    input wire logic sof_pulse,
    input wire logic standby_req,
    input wire logic bus_tx_data,
    input wire logic transmit_irq_flag,
    input wire logic transmit_irq_enable,
    input wire logic receive_irq_flag,
    input wire logic receive_irq_enable,
    // error events
    input wire logic crc_err_evt,
    input wire logic [15:0] crc_value,
    input wire logic fmt_err_evt,
    input wire logic single_err_evt,
    input wire logic double_err_evt,
    input wire logic [11:0] err_addr,
    // clock and power control
    output logic pll_select_q,
    output logic sysclk_en_q,
    output logic clock_out_pin_q,
    output logic asleep_q,
    output logic deep_sleep_state_q,
    output logic wake_to_config_q,
    // ram correction control
    output logic ram_correction_en_q,
    output logic [6:0] ram_parity_q,
    output logic err_irq_q,
    // pins
    input wire logic irq_pin_zero_i,
    output logic irq_pin_zero_o_q,
    output logic irq_pin_zero_oe_q,
    input wire logic irq_pin_one_i,
    output logic irq_pin_one_o_q,
    output logic irq_pin_one_oe_q,
    output logic bus_tx_o_q,
    output logic bus_tx_oe_q,
    output logic xcvr_standby_pin_q
);

    ccsr_pkg::ccsr_state_t state_q, state_d;
    logic [31:0] osc_q, osc_d, io_q, io_d, crc_ie_q, crc_ie_d, ecc_q, ecc_d;
    logic osc_off_q, osc_off_d, sclk_sync1_q, sclk_sync2_q, clk_ready_q, pll_lock_q;
    logic [1:0] gpio_lvl_q;
    logic crc_flag_q, fmt_flag_q, sec_flag_q, ded_flag_q;
    logic [15:0] crc_val_q;
    logic [11:0] err_addr_q;
    logic [3:0] clock_out_pin_cnt_q;
    logic clock_out_pin_div_q, half_ph_q;

    // decode
    wire awake = (state_q == ccsr_pkg::ST_AWAKE);
    wire reg_we = reg_req.wr && (state_q != ccsr_pkg::ST_DEEP);
    wire sel_osc = (reg_req.addr == ccsr_pkg::OFS_OSC);
    wire sel_io = (reg_req.addr == ccsr_pkg::OFS_PIN_IO);
    wire sel_crc = (reg_req.addr == ccsr_pkg::OFS_CRC);
    wire sel_eccc = (reg_req.addr == ccsr_pkg::OFS_RAM_CORR_CTRL);
    wire sel_eccs = (reg_req.addr == ccsr_pkg::OFS_RAM_CORR_STAT);
    wire sel_id = (reg_req.addr == ccsr_pkg::OFS_PART_ID);
    // each byte lane stands alone, so a one-byte write leaves the others intact
    wire [31:0] lane_m = {{8{reg_req.be[3]}}, {8{reg_req.be[2]}},
                          {8{reg_req.be[1]}}, {8{reg_req.be[0]}}};
    wire [31:0] wr_bits = lane_m & reg_req.wdata;
    wire [31:0] clr_bits = lane_m & ~reg_req.wdata;

    // sleep control
    wire bus_wake = bus_rx_activity && wake_irq_enable;
    wire host_wake = reg_we && sel_osc && clr_bits[ccsr_pkg::OSC_OFF];
    wire sleep_go = awake && sleep_request;
    wire sleep_exit = (state_q == ccsr_pkg::ST_SLEEP) && (host_wake || bus_wake);
    wire deep_exit = (state_q == ccsr_pkg::ST_DEEP) && (cs_asserted || bus_wake);
    // a wake from deep sleep brings every register back to its reset value
    wire soft_clr = deep_exit;

    always_comb begin
        case (state_q)
            ccsr_pkg::ST_AWAKE: begin
                if (sleep_request) begin
                    // the select bit only matters at this moment
                    state_d = osc_q[ccsr_pkg::OSC_DEEP_SEL] ?
                              ccsr_pkg::ST_DEEP : ccsr_pkg::ST_SLEEP;
                end else begin
                    state_d = ccsr_pkg::ST_AWAKE;
                end
            end
            ccsr_pkg::ST_SLEEP: state_d = sleep_exit ? ccsr_pkg::ST_AWAKE : ccsr_pkg::ST_SLEEP;
            ccsr_pkg::ST_DEEP: state_d = deep_exit ? ccsr_pkg::ST_AWAKE : ccsr_pkg::ST_DEEP;
            default: state_d = ccsr_pkg::ST_AWAKE;
        endcase
    end

    // hardware set on entry; host clear in sleep wakes
    assign osc_off_d = sleep_go || (osc_off_q && !sleep_exit && !deep_exit);

    // configuration-only bits are masked outside configuration mode
    wire [31:0] osc_m = lane_m & ccsr_pkg::OSC_WMASK &
                        (config_mode ? 32'hffff_ffff : ~ccsr_pkg::OSC_CFG_ONLY);
    assign osc_d = soft_clr ? ccsr_pkg::OSC_RST :
                   (reg_we && sel_osc) ? ((osc_q & ~osc_m) | (reg_req.wdata & osc_m)) : osc_q;

    wire [31:0] io_m = lane_m & ccsr_pkg::IO_WMASK;
    assign io_d = soft_clr ? ccsr_pkg::IO_RST :
                  (reg_we && sel_io) ? ((io_q & ~io_m) | (reg_req.wdata & io_m)) : io_q;

    wire [31:0] crc_m = lane_m & ccsr_pkg::CRC_WMASK;
    assign crc_ie_d = soft_clr ? 32'h0000_0000 :
                      (reg_we && sel_crc) ? ((crc_ie_q & ~crc_m) | (reg_req.wdata & crc_m)) :
                      crc_ie_q;

    wire [31:0] ecc_m = lane_m & ccsr_pkg::ECC_WMASK;
    assign ecc_d = soft_clr ? ccsr_pkg::ECC_RST :
                   (reg_we && sel_eccc) ? ((ecc_q & ~ecc_m) | (reg_req.wdata & ecc_m)) :
                   ecc_q;

    // flags clear on a written zero; a new event in that cycle wins
    wire crc_clr = reg_we && sel_crc && clr_bits[ccsr_pkg::CRC_ERR_FLAG];
    wire fmt_clr = reg_we && sel_crc && clr_bits[ccsr_pkg::CRC_FMT_FLAG];
    wire sec_clr = reg_we && sel_eccs && clr_bits[ccsr_pkg::ECC_SEC_FLAG];
    wire ded_clr = reg_we && sel_eccs && clr_bits[ccsr_pkg::ECC_DED_FLAG];
    wire ram_evt = single_err_evt || double_err_evt;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ccsr_pkg::ST_AWAKE;
            osc_q <= ccsr_pkg::OSC_RST;
            osc_off_q <= 1'b0;
            io_q <= ccsr_pkg::IO_RST;
            crc_ie_q <= 32'h0000_0000;
            ecc_q <= ccsr_pkg::ECC_RST;
        end else begin
            state_q <= state_d;
            osc_q <= osc_d;
            osc_off_q <= osc_off_d;
            io_q <= io_d;
            crc_ie_q <= crc_ie_d;
            ecc_q <= ecc_d;
        end
    end

    // error capture
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            crc_flag_q <= 1'b0;
            fmt_flag_q <= 1'b0;
            crc_val_q <= 16'h0000;
            sec_flag_q <= 1'b0;
            ded_flag_q <= 1'b0;
            err_addr_q <= 12'h000;
        end else if (soft_clr) begin
            crc_flag_q <= 1'b0;
            fmt_flag_q <= 1'b0;
            crc_val_q <= 16'h0000;
            sec_flag_q <= 1'b0;
            ded_flag_q <= 1'b0;
            err_addr_q <= 12'h000;
        end else begin
            crc_flag_q <= crc_err_evt || (crc_flag_q && !crc_clr);
            fmt_flag_q <= fmt_err_evt || (fmt_flag_q && !fmt_clr);
            if (crc_err_evt) begin
                crc_val_q <= crc_value;
            end
            sec_flag_q <= single_err_evt || (sec_flag_q && !sec_clr);
            ded_flag_q <= double_err_evt || (ded_flag_q && !ded_clr);
            if (ram_evt) begin
                err_addr_q <= err_addr;
            end
        end
    end

    // clock status
    wire clk_ready_d = awake && !osc_off_q && osc_stable;
    wire pll_lock_d = osc_q[ccsr_pkg::OSC_PLL_SEL] && pll_locked;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sync1_q <= 1'b0;
            sclk_sync2_q <= 1'b0;
            clk_ready_q <= 1'b0;
            pll_lock_q <= 1'b0;
            gpio_lvl_q <= 2'b00;
        end else begin
            sclk_sync1_q <= osc_q[ccsr_pkg::OSC_HALF];
            sclk_sync2_q <= sclk_sync1_q;
            clk_ready_q <= clk_ready_d;
            pll_lock_q <= pll_lock_d;
            gpio_lvl_q <= {irq_pin_one_i, irq_pin_zero_i};
        end
    end

    // clock output divider and system clock halving
    wire [1:0] div_code = osc_q[ccsr_pkg::OSC_DIV_HI:ccsr_pkg::OSC_DIV_LO];
    wire [3:0] clock_out_pin_half = (div_code == 2'b00) ? ccsr_pkg::CLOCK_OUT_PIN_HALF_DIV1 :
                           (div_code == 2'b01) ? ccsr_pkg::CLOCK_OUT_PIN_HALF_DIV2 :
                           (div_code == 2'b10) ? ccsr_pkg::CLOCK_OUT_PIN_HALF_DIV4 :
                           ccsr_pkg::CLOCK_OUT_PIN_HALF_DIV10;
    wire clock_out_pin_wrap = (clock_out_pin_cnt_q >= clock_out_pin_half - 4'h1);
    wire running = awake && !osc_off_q;
    wire half_sel = osc_q[ccsr_pkg::OSC_HALF];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clock_out_pin_cnt_q <= 4'h0;
            clock_out_pin_div_q <= 1'b0;
            half_ph_q <= 1'b0;
        end else if (!running) begin
            // stopped clock parks low so the first edge after wake is clean
            clock_out_pin_cnt_q <= 4'h0;
            clock_out_pin_div_q <= 1'b0;
            half_ph_q <= 1'b0;
        end else begin
            clock_out_pin_cnt_q <= clock_out_pin_wrap ? 4'h0 : clock_out_pin_cnt_q + 4'h1;
            clock_out_pin_div_q <= clock_out_pin_wrap ? !clock_out_pin_div_q : clock_out_pin_div_q;
            half_ph_q <= half_sel ? !half_ph_q : 1'b0;
        end
    end

    // pin drivers: interrupt pins are active low
    function automatic logic [1:0] pin_drive(input logic gpio, input logic dir,
                                             input logic lat, input logic irq, input logic od);
        logic lvl;
        logic drv;
        lvl = gpio ? lat : !irq;
        drv = gpio ? !dir : 1'b1;
        // open drain only ever pulls low
        pin_drive = od ? {1'b0, drv && !lvl} : {lvl, drv};
    endfunction

    wire irq0_act = transmit_irq_flag && transmit_irq_enable;
    wire irq1_act = receive_irq_flag && receive_irq_enable;
    wire [1:0] pin0_d = pin_drive(io_q[ccsr_pkg::IO_FN0], io_q[ccsr_pkg::IO_DIR0],
                                  io_q[ccsr_pkg::IO_PIN0_DRIVE_LATCH], irq0_act, io_q[ccsr_pkg::IO_IRQ_OD]);
    wire [1:0] pin1_d = pin_drive(io_q[ccsr_pkg::IO_FN1], io_q[ccsr_pkg::IO_DIR1],
                                  io_q[ccsr_pkg::IO_PIN1_DRIVE_LATCH], irq1_act, io_q[ccsr_pkg::IO_IRQ_OD]);
    wire tx_od = io_q[ccsr_pkg::IO_TX_OD];
    wire clock_out_pin_d = io_q[ccsr_pkg::IO_SOF_SEL] ? sof_pulse : clock_out_pin_div_q;
    wire stby_d = io_q[ccsr_pkg::IO_STBY_EN] && standby_req;
    wire err_irq_d = (crc_flag_q && crc_ie_q[ccsr_pkg::CRC_ERR_IE]) ||
                     (fmt_flag_q && crc_ie_q[ccsr_pkg::CRC_FMT_IE]) ||
                     (sec_flag_q && ecc_q[ccsr_pkg::ECC_SEC_IE]) ||
                     (ded_flag_q && ecc_q[ccsr_pkg::ECC_DED_IE]);

    // read data
    wire [31:0] osc_rd = {19'h0, sclk_sync2_q, 1'b0, clk_ready_q, 1'b0, pll_lock_q,
                          osc_q[7:3], osc_off_q, osc_q[1:0]};
    wire [31:0] io_rd = (io_q & ccsr_pkg::IO_WMASK) | {14'h0, gpio_lvl_q, 16'h0};
    wire [31:0] crc_rd = {crc_ie_q[31:24], 6'h0, fmt_flag_q, crc_flag_q, crc_val_q};
    wire [31:0] eccs_rd = {4'h0, err_addr_q, 13'h0, ded_flag_q, sec_flag_q, 1'b0};
    wire [31:0] id_rd = {24'h0, DEV_ID, DEV_REV};
    wire [31:0] rd_mux = (state_q == ccsr_pkg::ST_DEEP) ? 32'h0000_0000 :
                         sel_osc ? osc_rd : sel_io ? io_rd : sel_crc ? crc_rd :
                         sel_eccc ? ecc_q : sel_eccs ? eccs_rd : sel_id ? id_rd : 32'h0000_0000;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 32'h0000_0000;
            reg_rvalid_q <= 1'b0;
            pll_select_q <= 1'b0;
            sysclk_en_q <= 1'b0;
            clock_out_pin_q <= 1'b0;
            asleep_q <= 1'b0;
            deep_sleep_state_q <= 1'b0;
            wake_to_config_q <= 1'b0;
            ram_correction_en_q <= 1'b0;
            ram_parity_q <= 7'h00;
            err_irq_q <= 1'b0;
            {irq_pin_zero_o_q, irq_pin_zero_oe_q} <= 2'b00;
            {irq_pin_one_o_q, irq_pin_one_oe_q} <= 2'b00;
            bus_tx_o_q <= 1'b0;
            bus_tx_oe_q <= 1'b0;
            xcvr_standby_pin_q <= 1'b0;
        end else begin
            reg_rdata_q <= reg_req.rd ? rd_mux : 32'h0000_0000;
            reg_rvalid_q <= reg_req.rd;
            pll_select_q <= osc_q[ccsr_pkg::OSC_PLL_SEL];
            sysclk_en_q <= running && (!half_sel || half_ph_q);
            clock_out_pin_q <= running && clock_out_pin_d;
            asleep_q <= !awake;
            deep_sleep_state_q <= (state_q == ccsr_pkg::ST_DEEP);
            wake_to_config_q <= sleep_exit || deep_exit;
            ram_correction_en_q <= ecc_q[ccsr_pkg::ECC_EN];
            ram_parity_q <= ecc_q[ccsr_pkg::ECC_PAR_HI:ccsr_pkg::ECC_PAR_LO];
            err_irq_q <= err_irq_d;
            {irq_pin_zero_o_q, irq_pin_zero_oe_q} <= pin0_d;
            {irq_pin_one_o_q, irq_pin_one_oe_q} <= pin1_d;
            bus_tx_o_q <= tx_od ? 1'b0 : bus_tx_data;
            bus_tx_oe_q <= tx_od ? !bus_tx_data : 1'b1;
            xcvr_standby_pin_q <= stby_d;
        end
    end

    sequence s_light_entry;
        awake && sleep_request && !osc_q[ccsr_pkg::OSC_DEEP_SEL];
    endsequence

    sequence s_host_wake;
        (state_q == ccsr_pkg::ST_SLEEP) && host_wake;
    endsequence

    cfg_write_lock_a: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_we && sel_osc && !config_mode) |=>
            $stable(osc_q[ccsr_pkg::OSC_HALF]) && $stable(osc_q[ccsr_pkg::OSC_PLL_SEL]))
        else $error("half or pll select changed outside configuration");

    sync_delay_a: assert property (@(posedge clock) disable iff (!arst_n)
        ##2 (sclk_sync2_q == $past(osc_q[ccsr_pkg::OSC_HALF], 2)))
        else $error("synced half select not two cycles behind");

    clock_ready_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_ready_q |-> $past(osc_stable) && !$past(osc_off_q) && !asleep_q)
        else $error("clock ready without stable running clock");

    light_sleep_a: assert property (@(posedge clock) disable iff (!arst_n)
        s_light_entry |=> osc_off_q && (state_q == ccsr_pkg::ST_SLEEP) ##1 asleep_q)
        else $error("sleep entry did not set oscillator off");

    host_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
        s_host_wake |=> awake && !osc_off_q && wake_to_config_q)
        else $error("clearing oscillator off did not wake");

    deep_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
        ((state_q == ccsr_pkg::ST_DEEP) && cs_asserted) |=>
            awake && (osc_q == ccsr_pkg::OSC_RST) && (io_q == ccsr_pkg::IO_RST))
        else $error("deep wake did not restore registers");

    bus_wake_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
        ((state_q == ccsr_pkg::ST_SLEEP) && bus_rx_activity && !wake_irq_enable && !host_wake)
            |=> (state_q == ccsr_pkg::ST_SLEEP))
        else $error("bus activity woke without wake enable");

    irq0_pin_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!io_q[ccsr_pkg::IO_FN0] && irq0_act) |=> irq_pin_zero_oe_q && !irq_pin_zero_o_q)
        else $error("interrupt pin zero not asserted low");

    crc_capture_a: assert property (@(posedge clock) disable iff (!arst_n)
        (crc_err_evt && !soft_clr) |=> crc_flag_q && (crc_val_q == $past(crc_value)))
        else $error("crc mismatch not captured");

    err_request_a: assert property (@(posedge clock) disable iff (!arst_n)
        (ded_flag_q && ecc_q[ccsr_pkg::ECC_DED_IE]) |=> err_irq_q)
        else $error("error request missing for double error");

endmodule

`default_nettype wire

// ---- tb/ccsr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccsr_host (
    // clock
    input wire logic clock,
    // register port
    output var ccsr_pkg::ccsr_req_t req,
    input wire logic [31:0] rdata,
    input wire logic rvalid
);
    int gap = 0;
    initial req = '0;
    // host may idle between commands; pin control gets one lane per write
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        repeat (gap) @(negedge clock);
        @(negedge clock);
        req = '{1'b1, 1'b0, a, be, d};
        @(negedge clock);
        req = '0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge clock);
        req = '{1'b0, 1'b1, a, 4'hf, 32'h0};
        @(negedge clock);
        d = rvalid ? rdata : 32'hxxxx_xxxx;
        req = '0;
    endtask
endmodule
`default_nettype wire

// ---- tb/can_ctrl_system_control_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_system_control_regs_bench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cfg = 1, slp = 0, wie = 0, cs = 0, rxa = 0, oscs = 1, pll = 0, sof = 0, stby = 0;
    logic txd = 0, tf = 0, te = 0, rf = 0, re = 0, crce = 0, fmte = 0, sece = 0, dede = 0;
    logic p0 = 0, p1 = 0, rvalid, plls, sce, cko, asl, dss, wtc, rce, eirq;
    logic p0o, p0oe, p1o, p1oe, txo, txoe, xs;
    logic [15:0] crcv = 16'h0;
    logic [11:0] ea = 12'h0;
    logic [6:0] par;
    logic [31:0] rdata, d, r, rnd = 32'h6797;
    ccsr_pkg::ccsr_req_t req;
    int errors = 0, cmp_count = 0, n;
    always #4 clock = ~clock;
    ccsr_host ccsr_host_inst (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
    ccsr_regs ccsr_regs_inst (.clock(clock), .arst_n(arst_n), .reg_req(req),
        .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .config_mode(cfg), .sleep_request(slp),
        .wake_irq_enable(wie), .cs_asserted(cs), .bus_rx_activity(rxa), .osc_stable(oscs),
        .pll_locked(pll), .sof_pulse(sof), .standby_req(stby), .bus_tx_data(txd),
        .transmit_irq_flag(tf), .transmit_irq_enable(te), .receive_irq_flag(rf),
        .receive_irq_enable(re), .crc_err_evt(crce), .crc_value(crcv), .fmt_err_evt(fmte),
        .single_err_evt(sece), .double_err_evt(dede), .err_addr(ea), .pll_select_q(plls),
        .sysclk_en_q(sce), .clock_out_pin_q(cko), .asleep_q(asl), .deep_sleep_state_q(dss),
        .wake_to_config_q(wtc), .ram_correction_en_q(rce), .ram_parity_q(par),
        .err_irq_q(eirq), .irq_pin_zero_i(p0), .irq_pin_zero_o_q(p0o),
        .irq_pin_zero_oe_q(p0oe), .irq_pin_one_i(p1), .irq_pin_one_o_q(p1o),
        .irq_pin_one_oe_q(p1oe), .bus_tx_o_q(txo), .bus_tx_oe_q(txoe),
        .xcvr_standby_pin_q(xs));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // full clock-out period per divisor code
    function automatic int clock_out_pin_period(input logic [1:0] c);
        return (c == 2'b00) ? 2 : (c == 2'b01) ? 4 : (c == 2'b10) ? 8 : 20;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic measure(output int p);
        int i, e1;
        logic last;
        e1 = -1;
        p = 0;
        last = cko;
        for (i = 0; i < 80; i++) begin
            @(posedge clock);
            #1;
            if (cko === 1'b1 && last === 1'b0) begin
                if (e1 >= 0 && p == 0) p = i - e1;
                e1 = i;
            end
            last = cko;
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    initial begin
        #160000;
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        ccsr_host_inst.rd(ccsr_pkg::OFS_OSC, r); check(r, 32'h0000_0460);
        ccsr_host_inst.rd(ccsr_pkg::OFS_PIN_IO, r); check(r, ccsr_pkg::IO_RST);
        ccsr_host_inst.rd(ccsr_pkg::OFS_PART_ID, r); check(r, 32'h0000_0051);
        ccsr_host_inst.rd(12'h018, r); check(r, 32'h0);
        $display("reset values done");
        for (int c = 0; c < 4; c++) begin
            ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, {25'h0, c[1:0], 5'h0});
            measure(n); check(n, clock_out_pin_period(c[1:0]));
        end
        $display("clock divisor done");
        cfg = 0;
        ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, 32'h71);
        ccsr_host_inst.rd(ccsr_pkg::OFS_OSC, r); check(r[4], 1'b0);
        check(plls, 1'b0);
        cfg = 1;
        ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, 32'h71);
        repeat (6) @(negedge clock);
        ccsr_host_inst.rd(ccsr_pkg::OFS_OSC, r); check(r[12], 1'b1);
        r[0] = sce;
        @(negedge clock);
        check({plls, sce ^ r[0]}, 2'b11);
        ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, 32'h60);
        $display("config gating done");
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            crcv = rnd[15:0];
            ea = rnd[27:16];
            ccsr_host_inst.gap = rnd[1:0];
            ccsr_host_inst.wr(ccsr_pkg::OFS_CRC, 4'h8, {6'h0, rnd[31:30], 24'h0});
            pulse(crce);
            pulse(fmte);
            ccsr_host_inst.rd(ccsr_pkg::OFS_CRC, r);
            check(r, {6'h0, rnd[31:30], 6'h0, 2'b11, rnd[15:0]});
            check(eirq, |rnd[31:30]);
            ccsr_host_inst.wr(ccsr_pkg::OFS_CRC, 4'h4, 32'h0);
            repeat (2) @(negedge clock);
            check(eirq, 1'b0);
            ccsr_host_inst.wr(ccsr_pkg::OFS_RAM_CORR_CTRL, 4'h3,
                              {17'h0, rnd[14:8], 5'h0, rnd[2:0]});
            // control copies are registered one cycle after the register itself
            @(negedge clock);
            check({par, rce}, {rnd[14:8], rnd[0]});
            pulse(sece);
            pulse(dede);
            ccsr_host_inst.rd(ccsr_pkg::OFS_RAM_CORR_STAT, r);
            check(r, {4'h0, rnd[27:16], 16'h0006});
            check(eirq, |rnd[2:1]);
            ccsr_host_inst.wr(ccsr_pkg::OFS_RAM_CORR_STAT, 4'h1, 32'h0);
        end
        $display("error capture done");
        tf = 1; te = 1; txd = rnd[5];
        ccsr_host_inst.wr(ccsr_pkg::OFS_PIN_IO, 4'h8, 32'h0);
        repeat (2) @(negedge clock);
        check({p0o, p0oe, txo, txoe}, {3'b010, 1'b1} | {2'b0, txd, 1'b0});
        tf = 0;
        ccsr_host_inst.wr(ccsr_pkg::OFS_PIN_IO, 4'h8, 32'h5000_0000);
        repeat (2) @(negedge clock);
        check({p0oe, txo, txoe}, {2'b00, ~txd});
        ccsr_host_inst.wr(ccsr_pkg::OFS_PIN_IO, 4'h8, 32'h2000_0000);
        sof = 1'b1;
        repeat (3) @(negedge clock);
        check(cko, 1'b1);
        sof = 1'b0;
        stby = 1'b1;
        check(xs, 1'b0);
        ccsr_host_inst.wr(ccsr_pkg::OFS_PIN_IO, 4'h1, 32'h40);
        repeat (2) @(negedge clock);
        check(xs, 1'b1);
        $display("pin control done");
        pulse(slp);
        check({asl, sce}, 2'b10);
        ccsr_host_inst.rd(ccsr_pkg::OFS_OSC, r); check(r[2], 1'b1);
        ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, 32'h60);
        repeat (2) @(negedge clock);
        check(asl, 1'b0);
        ccsr_host_inst.wr(ccsr_pkg::OFS_OSC, 4'h1, 32'h68);
        check(asl, 1'b0);
        pulse(slp);
        check(dss, 1'b1);
        pulse(cs);
        ccsr_host_inst.rd(ccsr_pkg::OFS_RAM_CORR_CTRL, r); check(r, ccsr_pkg::ECC_RST);
        $display("sleep modes done");
        summarize();
    end
endmodule
`default_nettype wire
